// file: rtl/chr_host_regs.sv
// Host register interface of the wavelet codec
module chr_host_regs
  import chr_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int CW = $clog2(DEPTH) + 1
)
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Host register port, synchronous one-cycle strobes
  input wire logic [3:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] WDATA_I,
  output logic [31:0] RDATA_O,
  output logic RACK_O,
  // Encoder stream source
  input wire logic ENC_PUSH_I,
  input wire logic [31:0] ENC_DATA_I,
  input wire logic ENC_LAST_I,
  // Decoder stream sink
  input wire logic DEC_REQ_I,
  output logic [31:0] DEC_DATA_O,
  output logic DEC_VALID_O,
  // Datapath events
  input wire logic SYNC_ERR_I,
  input wire logic STATS_I,
  input wire logic DRAM_ERR_I,
  input wire logic FIELD_END_I,
  // Status pins
  output logic HOST_IRQ_O,
  output logic STATS_READY_O,
  output logic LAST_WORD_O,
  output logic FIFO_SERVICE_O,
  output logic FIFO_FAULT_O,
  output logic FIFO_HALT_O,
  // Mode controls to the datapath
  output logic [3:0] VIDEO_FORMAT_O,
  output logic CLK_HALVE_O,
  output logic SYNC_DRIVE_O,
  output logic LINES625_O,
  output logic ENCODE_O,
  output logic UNIPOLAR_O,
  output logic HSYNC_POL_O,
  output logic FOCUS_BOX_O,
  output logic PROC_RUN_O
);

  chr_mode_t mode_r;           // Mode control register
  chr_fctl_t fctl_r;           // FIFO service levels
  logic [15:0] index_r;        // Indirect index
  logic [6:0] mask_r;          // Interrupt enables
  logic run_r;                 // Processing allowed
  logic srq_r;                 // Live service request
  logic irq_r;                 // Interrupt pin level
  logic [31:0] rdata_r;        // Host read data
  logic rack_r;                // Host read answer
  logic [31:0] dec_data_r;     // Word to the decoder
  logic dec_valid_r;           // Decoder word strobe
  logic stats_ready_pin;               // Statistics pin
  logic last_r;                // Last word pin
  logic fault_r;               // Fault pin pulse
  logic halt_r;                // Stop pin

  // Access decode
  logic wr_index;
  logic win_wr;
  logic win_rd;
  logic win_acc;
  logic st_wr;
  logic st_rd;
  logic irq_rd;
  logic irq_wr;

  // Buffer handshake
  logic [FIFO_WIDTH:0] f_wdata;
  logic [FIFO_WIDTH:0] f_rdata;
  logic [CW-1:0] f_count;
  logic f_full;
  logic f_empty;
  logic enc_push;
  logic dec_push;
  logic host_pop;
  logic dec_pop;
  logic fault_evt;

  // Status conditions
  logic [CW-1:0] enc_level;
  logic [CW-1:0] dec_level;
  logic last_cond;
  logic srq_cond;
  logic halt_cond;
  logic [6:0] ev;
  logic [6:0] status;
  logic [15:0] irq_word;
  logic [15:0] win_rdata;
  logic pending;

  assign wr_index = WR_I && (ADDR_I == OFS_INDEX);
  assign win_wr = WR_I && (ADDR_I == OFS_WINDOW);
  assign win_rd = RD_I && (ADDR_I == OFS_WINDOW);
  assign win_acc = win_wr || win_rd;
  assign st_wr = WR_I && (ADDR_I == OFS_STREAM);
  assign st_rd = RD_I && (ADDR_I == OFS_STREAM);
  assign irq_rd = RD_I && (ADDR_I == OFS_IRQ);
  assign irq_wr = WR_I && (ADDR_I == OFS_IRQ);

  // Index register; each window access moves it on by one
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      index_r <= '0;
    else if (wr_index)
      index_r <= WDATA_I[15:0];
    else if (win_acc)
      index_r <= index_r + IDX_STEP;
  end

  // Indirect writes; reserved mode bits are forced to zero
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      mode_r <= MODE_RESET;
      fctl_r <= FIFO_CTL_RESET;
    end
    else if (win_wr)
    begin
      if (index_r == IDX_MODE)
        mode_r <= WDATA_I[15:0] & MODE_WR_MASK;
      else if (index_r == IDX_FIFO_CTL)
        fctl_r <= WDATA_I[7:0];
    end
  end

  // Indirect read mux; unknown indices read as zero
  always_comb
  begin
    if (index_r == IDX_MODE)
      win_rdata = mode_r;
    else if (index_r == IDX_FIFO_CTL)
      win_rdata = {8'h00, fctl_r};
    else
      win_rdata = 16'h0000;
  end

  // Mode fields steer the datapath straight from the register
  assign VIDEO_FORMAT_O = mode_r.format;
  assign CLK_HALVE_O = mode_r.clk_halve;
  assign UNIPOLAR_O = mode_r.chroma_pol;
  assign SYNC_DRIVE_O = mode_r.master;
  assign LINES625_O = mode_r.lines625;
  assign ENCODE_O = mode_r.encode;
  assign HSYNC_POL_O = mode_r.hsync_pol;
  assign FOCUS_BOX_O = mode_r.focus_box;

  // Soft halt: decode stops at once, encode runs to the field end.
  // The host is trusted to hold the halt while changing mode bits.
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      run_r <= 1'b0;
    else if (!mode_r.soft_halt)
      run_r <= 1'b1;
    else if (!mode_r.encode)
      run_r <= 1'b0;
    else if (FIELD_END_I)
      run_r <= 1'b0;
  end
  assign PROC_RUN_O = run_r;

  // Buffer traffic; the top bit of each word tags the field's last
  assign enc_push = ENC_PUSH_I && mode_r.encode && !f_full;
  assign dec_push = st_wr && !mode_r.encode && !f_full;
  assign host_pop = st_rd && mode_r.encode && !f_empty;
  assign dec_pop = DEC_REQ_I && !mode_r.encode && !f_empty;
  assign f_wdata = mode_r.encode ? {ENC_LAST_I, ENC_DATA_I}
                                 : {1'b0, WDATA_I};

  // Overflow in encode, underflow or host overflow in decode
  assign fault_evt = (ENC_PUSH_I && mode_r.encode && f_full) ||
                     (st_wr && !mode_r.encode && f_full) ||
                     (DEC_REQ_I && !mode_r.encode && f_empty);

  chr_fifo #(
    .W(FIFO_WIDTH + 1),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .push_i(enc_push || dec_push),
    .wdata_i(f_wdata),
    .pop_i(host_pop || dec_pop),
    .rdata_o(f_rdata),
    .count_o(f_count),
    .full_o(f_full),
    .empty_o(f_empty)
  );

  // Decoder delivery, one cycle after the request
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      dec_data_r <= '0;
      dec_valid_r <= 1'b0;
    end
    else
    begin
      dec_valid_r <= dec_pop;
      if (dec_pop)
        dec_data_r <= f_rdata[FIFO_WIDTH-1:0];
    end
  end
  assign DEC_DATA_O = dec_data_r;
  assign DEC_VALID_O = dec_valid_r;

  // Service levels: encode counts fill, decode counts fill from below
  assign enc_level = CW'(fctl_r.encode_threshold) << LEVEL_SHIFT;
  assign dec_level = CW'(fctl_r.decode_threshold) << LEVEL_SHIFT;
  assign srq_cond = mode_r.encode
    ? ((fctl_r.encode_threshold != '0) && (f_count >= enc_level))
    : ((fctl_r.decode_threshold != '0) && (f_count <= dec_level));
  assign last_cond = mode_r.encode && !f_empty &&
                     f_rdata[FIFO_WIDTH];
  // Decode stop rises early so the host still has spare room
  assign halt_cond = mode_r.encode ? f_empty
    : (f_count >= CW'(DEPTH - HALT_MARGIN));

  // Pin images of the conditions
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      srq_r <= 1'b0;
      stats_ready_pin <= 1'b0;
      last_r <= 1'b0;
      fault_r <= 1'b0;
      halt_r <= 1'b0;
    end
    else
    begin
      srq_r <= srq_cond;
      stats_ready_pin <= STATS_I;
      last_r <= last_cond;
      fault_r <= fault_evt;
      halt_r <= halt_cond;
    end
  end
  assign FIFO_SERVICE_O = srq_r;
  assign STATS_READY_O = stats_ready_pin;
  assign LAST_WORD_O = last_r;
  assign FIFO_FAULT_O = fault_r;
  assign FIFO_HALT_O = halt_r;

  // Event sources in status bit order
  always_comb
  begin
    ev = '0;
    ev[ST_SYNC] = SYNC_ERR_I;
    ev[ST_STATS] = STATS_I;
    ev[ST_LAST] = last_cond;
    ev[ST_SRQ] = srq_cond;
    ev[ST_FAULT] = fault_evt;
    ev[ST_HALT] = halt_cond;
    ev[ST_DRAM] = DRAM_ERR_I;
  end

  // Sticky flags; the service bit alone stays live.
  // Sticky bits catch edges only, so polling cannot see a held level.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++)
    begin : g_flag
      if (gi == ST_SRQ)
      begin : g_live
        assign status[gi] = srq_r;
      end
      else
      begin : g_hold
        chr_sticky u_flag (
          .clk_i(CLK_I),
          .rst_i(RST_I),
          .cond_i(ev[gi]),
          .clr_i(irq_rd),
          .flag_o(status[gi])
        );
      end
    end
  endgenerate

  // Mask register; reserved bits 7 and 15 never store
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      mask_r <= '0;
    else if (irq_wr)
      mask_r <= WDATA_I[MASK_LSB +: NUM_EVENTS];
  end
  assign irq_word = {1'b0, mask_r, 1'b0, status};

  // Interrupt pin with selectable polarity; idle high after reset
  assign pending = |(status & mask_r);
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      irq_r <= 1'b1;
    else
      irq_r <= mode_r.irq_pol ? pending : !pending;
  end
  assign HOST_IRQ_O = irq_r;

  // Host read answer; write-only and idle lanes read as zero
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      rdata_r <= '0;
      rack_r <= 1'b0;
    end
    else
    begin
      rack_r <= RD_I;
      if (RD_I)
      begin
        case (ADDR_I)
          OFS_WINDOW: rdata_r <= {16'h0000, win_rdata};
          OFS_STREAM: rdata_r <= host_pop ? f_rdata[FIFO_WIDTH-1:0]
                                          : 32'h0000_0000;
          OFS_IRQ: rdata_r <= {16'h0000, irq_word};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign RDATA_O = rdata_r;
  assign RACK_O = rack_r;

  a_index_step: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    win_acc |=> (index_r == $past(index_r) + IDX_STEP))
    else $error("index did not step after a window access");

  a_irq_level: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    ##1 (HOST_IRQ_O == ($past(mode_r.irq_pol) ? $past(pending)
                                               : !$past(pending))))
    else $error("interrupt pin disagrees with masked status");

  a_read_clears: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    (irq_rd && (ev == '0)) |=> ((status & STICKY_SET) == '0))
    else $error("sticky flags survived a status read");

  a_srq_live: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    ##1 (status[ST_SRQ] == $past(srq_cond)))
    else $error("service bit does not track its condition");

  a_sync_error: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    (SYNC_ERR_I && !$past(SYNC_ERR_I)) |=> status[ST_SYNC])
    else $error("sync error edge did not set bit 0");

  a_last_word: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    (mode_r.encode && !f_empty && f_rdata[FIFO_WIDTH]) |=> LAST_WORD_O)
    else $error("last word pin missed a tagged head");

  a_overflow_flag: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    (st_wr && !mode_r.encode && f_full) |=> (FIFO_FAULT_O && status[ST_FAULT]))
    else $error("host overflow did not raise the fault");

  a_decode_stop: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    (!mode_r.encode && (f_count >= CW'(DEPTH - HALT_MARGIN))) |=> FIFO_HALT_O)
    else $error("decode stop missed the spare margin");

  a_halt_decode: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    (mode_r.soft_halt && !mode_r.encode) |=> !PROC_RUN_O)
    else $error("decode kept running under soft halt");

endmodule // chr_host_regs

// file: shared/chr_pkg.sv
// Constants, field layouts and carrier types for the codec host registers
package chr_pkg;

  // Direct register byte offsets on the host port
  localparam logic [3:0] OFS_INDEX = 4'h0;
  localparam logic [3:0] OFS_WINDOW = 4'h4;
  localparam logic [3:0] OFS_STREAM = 4'h8;
  localparam logic [3:0] OFS_IRQ = 4'hC;

  // Indirect register indices reached through the window
  localparam logic [15:0] IDX_MODE = 16'h0000;
  localparam logic [15:0] IDX_FIFO_CTL = 16'h0001;
  localparam logic [15:0] IDX_STEP = 16'h0001;

  // Reset values: encode mode with the soft halt set
  localparam logic [15:0] MODE_RESET = 16'h0880;
  localparam logic [15:0] MODE_WR_MASK = 16'hFAFF;
  localparam logic [7:0] FIFO_CTL_RESET = 8'h88;

  // Stream buffer geometry and level scaling
  localparam int FIFO_DEPTH = 512;
  localparam int FIFO_WIDTH = 32;
  localparam int LEVEL_SHIFT = 5;
  localparam int HALT_MARGIN = 32;

  // Status bit positions; mask bit of status i sits at MASK_LSB + i
  localparam int ST_SYNC = 0;
  localparam int ST_STATS = 1;
  localparam int ST_LAST = 2;
  localparam int ST_SRQ = 3;
  localparam int ST_FAULT = 4;
  localparam int ST_HALT = 5;
  localparam int ST_DRAM = 6;
  localparam int NUM_EVENTS = 7;
  localparam int MASK_LSB = 8;
  localparam logic [6:0] STICKY_SET = 7'h77;

  // Mode control register layout
  typedef struct packed {
    logic stall_en;       // Bit 15, stored and read back
    logic focus_box;      // Bit 14
    logic irq_pol;        // Bit 13, 1 = active high
    logic hsync_pol;      // Bit 12, 1 = low in blanking
    logic soft_halt;      // Bit 11
    logic rsv10;          // Reserved, kept zero
    logic chroma_pol;     // Bit 9, 1 = unipolar
    logic rsv8;           // Reserved, kept zero
    logic encode;         // Bit 7, 1 = encode
    logic lines625;       // Bit 6
    logic master;         // Bit 5, drive sync pins
    logic clk_halve;      // Bit 4
    logic [3:0] format;   // Bits 3:0
  } chr_mode_t;

  // FIFO control register layout
  typedef struct packed {
    logic [3:0] decode_threshold;
    logic [3:0] encode_threshold;
  } chr_fctl_t;

endpackage : chr_pkg

// file: rtl/chr_fifo.sv
// Stream buffer between host port and video datapath
module chr_fifo
  import chr_pkg::*;
#(
  parameter int W = FIFO_WIDTH + 1,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side, caller guarantees not full
  input wire logic push_i,
  input wire logic [W-1:0] wdata_i,
  // Drain side, caller guarantees not empty
  input wire logic pop_i,
  output logic [W-1:0] rdata_o,
  // Level
  output logic [AW:0] count_o,
  output logic full_o,
  output logic empty_o
);

  logic [W-1:0] mem [DEPTH];  // Storage, no reset needed
  logic [AW-1:0] wr_ptr_r;    // Next slot to fill
  logic [AW-1:0] rd_ptr_r;    // Head slot
  logic [AW:0] count_r;       // Words held

  // Storage write
  always_ff @(posedge clk_i)
  begin
    if (push_i)
      mem[wr_ptr_r] <= wdata_i;
  end

  // Pointers wrap on their own since the depth is a power of two
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push_i)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop_i)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push_i && !pop_i)
        count_r <= count_r + 1'b1;
      else if (pop_i && !push_i)
        count_r <= count_r - 1'b1;
    end
  end

  // Head word is shown ahead of the pop
  assign rdata_o = mem[rd_ptr_r];
  assign count_o = count_r;
  assign full_o = (count_r == (AW+1)'(DEPTH));
  assign empty_o = (count_r == '0);

endmodule // chr_fifo

// file: rtl/chr_sticky.sv
// Edge-set, read-clear status flag
module chr_sticky
  import chr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Condition level and host clear
  input wire logic cond_i,
  input wire logic clr_i,
  output logic flag_o
);

  logic prev_r;  // Condition one cycle back
  logic flag_r;  // Held flag
  logic rise;    // Positive edge of the condition

  assign rise = cond_i && !prev_r;

  // A new edge in the clearing cycle wins so no event is lost
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prev_r <= 1'b0;
      flag_r <= 1'b0;
    end
    else
    begin
      prev_r <= cond_i;
      if (rise)
        flag_r <= 1'b1;
      else if (clr_i)
        flag_r <= 1'b0;
    end
  end

  assign flag_o = flag_r;

  a_set_wins_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rise && clr_i) |=> flag_o)
    else $error("flag lost an edge that met a clear");

endmodule // chr_sticky

// file: verification/chr_host_model.sv
// Host processor model issuing register accesses on the codec port
module chr_host_model
  import chr_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Register strobes toward the device
  output logic [3:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [31:0] wdata_o,
  // Read answer from the device
  input wire logic [31:0] rdata_i,
  input wire logic rack_i
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus before the first access
  initial
  begin
    addr_o = 4'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 32'h0;
  end

  // One-cycle write; released lines turn over so stale values cannot pass
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask

  // One-cycle read, answer taken at the edge that sees the acknowledge
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    d = 'x;
    // Bounded wait: a missing answer leaves unknown data
    for (int n = 0; n < 4; n++)
    begin
      @(posedge clk_i);
      if (rack_i === 1'b1)
      begin
        d = rdata_i;
        break;
      end
    end
  endtask

  // Mode change bracketed by the soft halt
  task automatic set_mode(input logic [15:0] m);
    wr(OFS_INDEX, 32'h0);
    wr(OFS_WINDOW, {16'h0, m | 16'h0800});
    wr(OFS_INDEX, 32'h0);
    wr(OFS_WINDOW, {16'h0, m & ~16'h0800});
  endtask
endmodule // chr_host_model

// file: verification/chr_host_regs_bench.sv
// Self-checking bench for the codec host register block
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module chr_host_regs_bench
  import chr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // Clock, reset and host port
  logic clk, rst, wr, rd, rack;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, v;
  // Stream and event lines
  logic enc_push, enc_last, dec_req, dec_valid;
  logic [31:0] enc_data, dec_data;
  logic sync_err, stats, dram_err, field_end;
  // Status pins and mode outputs
  logic irq, stats_rdy, last_w, srv, fault, halt;
  logic [3:0] fmt;
  logic halve, sdrv, l625, enc, unip, hpol, fbox, run;
  int error_cnt;
  int comparisons;

  chr_host_regs #(.DEPTH(FIFO_DEPTH)) dut (
    .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WR_I(wr), .RD_I(rd),
    .WDATA_I(wdata), .RDATA_O(rdata), .RACK_O(rack),
    .ENC_PUSH_I(enc_push), .ENC_DATA_I(enc_data), .ENC_LAST_I(enc_last),
    .DEC_REQ_I(dec_req), .DEC_DATA_O(dec_data), .DEC_VALID_O(dec_valid),
    .SYNC_ERR_I(sync_err), .STATS_I(stats), .DRAM_ERR_I(dram_err),
    .FIELD_END_I(field_end), .HOST_IRQ_O(irq), .STATS_READY_O(stats_rdy),
    .LAST_WORD_O(last_w), .FIFO_SERVICE_O(srv), .FIFO_FAULT_O(fault),
    .FIFO_HALT_O(halt), .VIDEO_FORMAT_O(fmt), .CLK_HALVE_O(halve),
    .SYNC_DRIVE_O(sdrv), .LINES625_O(l625), .ENCODE_O(enc),
    .UNIPOLAR_O(unip), .HSYNC_POL_O(hpol), .FOCUS_BOX_O(fbox),
    .PROC_RUN_O(run)
  );

  chr_host_model host (
    .clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata),
    .rdata_i(rdata), .rack_i(rack)
  );

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Let edges land, then sample settled outputs
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Register read with comparison
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    host.rd(a, v);
    `CHK(v, e);
  endtask

  // Indirect read: index first, then the window
  task automatic indirect_data_window(input logic [15:0] idx, input logic [31:0] e);
    host.wr(OFS_INDEX, {16'h0, idx});
    rd_chk(OFS_WINDOW, e);
  endtask

  // Encoder word into the buffer
  task automatic push(input logic [31:0] d, input logic t);
    @(posedge clk);
    enc_push <= 1'b1;
    enc_data <= d;
    enc_last <= t;
    @(posedge clk);
    enc_push <= 1'b0;
    enc_data <= ~d;
  endtask

  // Decoder request; word expected one cycle later
  task automatic dreq(input logic [31:0] e);
    @(posedge clk);
    dec_req <= 1'b1;
    @(posedge clk);
    dec_req <= 1'b0;
    #1;
    `CHK(dec_valid, 1'b1);
    `CHK(dec_data, e);
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Hang guard, several times the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize();
  end

  // Main sequence
  initial
  begin
    error_cnt = 0;
    comparisons = 0;
    rst = 1'b1;
    {enc_push, enc_last, dec_req, sync_err, stats, dram_err} = 6'h00;
    field_end = 1'b0;
    enc_data = 32'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    `CHK({irq, run, enc}, 3'h5);
    // Reset contents; the index steps from mode to FIFO control
    host.wr(OFS_INDEX, 32'h0);
    rd_chk(OFS_WINDOW, 32'h0880);
    rd_chk(OFS_WINDOW, 32'h0088);
    rd_chk(OFS_INDEX, 32'h0);
    rd_chk(4'h2, 32'h0);
    tick(2);
    rd_chk(OFS_IRQ, 32'h0020);
    rd_chk(OFS_IRQ, 32'h0000);
    // Decode, every mode field but stall_en and soft_halt set; reserved bits written high
    host.set_mode(16'h7772);
    tick(2);
    `CHK({fmt, halve, sdrv, l625, enc}, 8'h2E);
    `CHK({unip, hpol, fbox, run, irq}, 5'h1E);
    indirect_data_window(IDX_MODE, 32'h7272);
    // Soft halt in decode stops at once
    host.wr(OFS_INDEX, 32'h0);
    host.wr(OFS_WINDOW, 32'h7A72);
    tick(1);
    `CHK(run, 1'b0);
    host.wr(OFS_INDEX, 32'h0);
    host.wr(OFS_WINDOW, 32'h7272);
    // Zero decode level disables the service request
    host.wr(OFS_INDEX, 32'h1);
    host.wr(OFS_WINDOW, 32'h08);
    tick(2);
    `CHK(srv, 1'b0);
    host.wr(OFS_INDEX, 32'h1);
    host.wr(OFS_WINDOW, 32'h88);
    tick(2);
    `CHK(srv, 1'b1);
    // Fill to the stop margin, then overflow by one word
    host.wr(OFS_IRQ, 32'h1000);
    for (int i = 0; i < 479; i++)
      host.wr(OFS_STREAM, 32'(i));
    tick(2);
    `CHK(halt, 1'b0);
    host.wr(OFS_STREAM, 32'd479);
    tick(2);
    `CHK(halt, 1'b1);
    for (int i = 480; i <= 512; i++)
      host.wr(OFS_STREAM, 32'(i));
    tick(2);
    `CHK(irq, 1'b1);
    rd_chk(OFS_IRQ, 32'h1030);
    tick(2);
    `CHK(irq, 1'b0);
    for (int i = 0; i < 512; i++)
      dreq(32'(i));
    // Request from an empty buffer underflows
    @(posedge clk);
    dec_req <= 1'b1;
    @(posedge clk);
    dec_req <= 1'b0;
    #1;
    `CHK(fault, 1'b1);
    tick(1);
    `CHK(dec_valid, 1'b0);
    tick(2);
    rd_chk(OFS_IRQ, 32'h1018);
    // Encode: last-word marking ahead of the final read
    host.set_mode(16'h0080);
    tick(3);
    host.rd(OFS_IRQ, v);
    push(32'hA0, 1'b0);
    push(32'hA1, 1'b0);
    push(32'hA2, 1'b1);
    tick(2);
    `CHK(last_w, 1'b0);
    rd_chk(OFS_STREAM, 32'hA0);
    rd_chk(OFS_STREAM, 32'hA1);
    tick(1);
    `CHK(last_w, 1'b1);
    rd_chk(OFS_STREAM, 32'hA2);
    tick(3);
    rd_chk(OFS_IRQ, 32'h1024);
    // Datapath events; interrupt now active low
    host.wr(OFS_IRQ, 32'h8180);
    @(posedge clk);
    sync_err <= 1'b1;
    stats <= 1'b1;
    dram_err <= 1'b1;
    tick(3);
    `CHK({stats_rdy, irq}, 2'h2);
    rd_chk(OFS_IRQ, 32'h0143);
    rd_chk(OFS_IRQ, 32'h0100);
    tick(2);
    `CHK(irq, 1'b1);
    // Soft halt in encode waits for the field end
    host.wr(OFS_INDEX, 32'h0);
    host.wr(OFS_WINDOW, 32'h0880);
    tick(3);
    `CHK(run, 1'b1);
    @(posedge clk);
    field_end <= 1'b1;
    @(posedge clk);
    field_end <= 1'b0;
    tick(1);
    `CHK(run, 1'b0);
    summarize();
  end
endmodule // chr_host_regs_bench
